// >>> src/pgs_sequencer.sv
`timescale 1ns/1ps
module pgs_sequencer import pgs_pkg::*; #(
	parameter int CNT_W = 27,
	parameter int DELAY_20_CYCLES = DLY_20_CYC,
	parameter int DELAY_100_CYCLES = DLY_100_CYC,
	parameter int DELAY_200_CYCLES = DLY_200_CYC,
	parameter int DELAY_400_CYCLES = DLY_400_CYC,
	parameter int ORDER_GAP_CYCLES = ORDER_GAP_CYC,
	parameter logic [7:0] MASK_RESET = MASK_DEFAULT,
	parameter logic [7:0] CTRL_RESET = CTRL_DEFAULT,
	parameter logic [1:0] DELAY_RESET = DELAY_DEFAULT
) (
	input wire logic MCLK_IN,
	input wire logic RESET_N_IN,
	input wire logic UNDERVOLTAGE_LOCKOUT_IN,
	input wire logic ON_STATE_IN,
	input wire logic BUCK_THREE_PIN_OVERRIDE_IN,
	input wire logic [4:0] RAIL_GOOD_IN,
	input wire logic RESET_COMPARATOR_IN,
	input wire logic BUCK_ONE_ENABLE_PIN_IN,
	input wire logic BUCK_TWO_ENABLE_PIN_IN,
	input wire logic BUCK_THREE_ENABLE_PIN_IN,
	input wire logic LINEAR_REG_ENABLE_PIN_IN,
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [7:0] REG_RDATA_OUT,
	output logic BUCK_ONE_RUN_OUT,
	output logic BUCK_TWO_RUN_OUT,
	output logic BUCK_THREE_RUN_OUT,
	output logic LINEAR_REG_ONE_RUN_OUT,
	output logic LINEAR_REG_TWO_RUN_OUT,
	output logic EXTERNAL_REGULATOR_ENABLE_OUT,
	output logic RAILS_OK_OUTPUT_OUT,
	output logic RAILS_OK_OUTPUT_OE_OUT
);
	// the counter must hold the longest delay, a zero delay would release at once
	if (DELAY_400_CYCLES >= (1 << CNT_W) ||
			ORDER_GAP_CYCLES >= (1 << CNT_W)) begin : g_cnt_chk
		$error("pgs_sequencer: CNT_W too small for the delays");
	end
	if (DELAY_20_CYCLES < 1 || ORDER_GAP_CYCLES < 1) begin : g_dly_chk
		$error("pgs_sequencer: delays must be at least one cycle");
	end

	// rails of one stage of the selected order
	function automatic logic [4:0] stage_rails(input logic [2:0] code, input logic [1:0] k,
			input logic ovr);
		logic [4:0] r;
		r = SET_NONE;
		unique case (code)
			ORD_B2: begin
				if (k == LVL_ZERO) r[S_B2] = 1'b1;
			end
			ORD_B2B3: begin
				if (k == LVL_ZERO) r[S_B2] = 1'b1;
				if (k == LVL_ZERO) r[S_B3] = 1'b1;
			end
			ORD_B1_THEN_B2B3: begin
				if (k == LVL_ZERO) r[S_B1] = 1'b1;
				if (k == LVL_ONE) r[S_B2] = 1'b1;
				if (k == LVL_ONE) r[S_B3] = 1'b1;
			end
			ORD_B3_THEN_B2: begin
				if (k == LVL_ZERO) r[S_B3] = 1'b1;
				if (k == LVL_ONE) r[S_B2] = 1'b1;
			end
			ORD_L2_THEN_B1B2: begin
				if (k == LVL_ZERO) r[S_L2] = 1'b1;
				if (k == LVL_ZERO) r[S_B3] = ovr;
				if (k == LVL_ONE) r[S_B1] = 1'b1;
				if (k == LVL_ONE) r[S_B2] = 1'b1;
			end
			ORD_PINS: begin
				r = SET_NONE;
			end
			ORD_B1_B2_B3: begin
				if (k == LVL_ZERO) r[S_B1] = 1'b1;
				if (k == LVL_ONE) r[S_B2] = 1'b1;
				if (k == LVL_TWO) r[S_B3] = 1'b1;
			end
			ORD_EXT_L2_B1B2: begin
				if (k == LVL_ZERO) r[S_EXT] = 1'b1;
				if (k == LVL_ONE) r[S_L2] = 1'b1;
				if (k == LVL_TWO) r[S_B1] = 1'b1;
				if (k == LVL_TWO) r[S_B2] = 1'b1;
			end
		endcase
		return r;
	endfunction

	// union of stages below lvl
	function automatic logic [4:0] stages_below(input logic [2:0] code, input logic [1:0] lvl,
			input logic ovr);
		logic [4:0] r;
		r = SET_NONE;
		for (int k = 0; k < 3; k++) begin
			if (k < int'(lvl)) r = r | stage_rails(code, 2'(k), ovr);
		end
		return r;
	endfunction

	logic [9:0] pins_s;
	logic [4:0] good_s;
	logic comp_s;
	logic pin_b1_s;
	logic pin_b2_s;
	logic pin_b3_s;
	logic pin_l_s;

	pgs_sync #(.WIDTH(10)) u_sync (
		.clk_in(MCLK_IN),
		.rst_n_in(RESET_N_IN),
		.async_in({RESET_COMPARATOR_IN, LINEAR_REG_ENABLE_PIN_IN, BUCK_THREE_ENABLE_PIN_IN,
			BUCK_TWO_ENABLE_PIN_IN, BUCK_ONE_ENABLE_PIN_IN, RAIL_GOOD_IN}),
		.sync_out(pins_s)
	);

	assign good_s = pins_s[4:0];
	assign pin_b1_s = pins_s[5];
	assign pin_b2_s = pins_s[6];
	assign pin_b3_s = pins_s[7];
	assign pin_l_s = pins_s[8];
	assign comp_s = pins_s[9];

	logic [7:0] mask_q;
	logic [7:0] ctrl_q;
	logic [1:0] dly_q;
	logic wr_mask;
	logic wr_ctrl;
	logic wr_stat;

	assign wr_mask = REG_WR_IN && (REG_ADDR_IN == ADDR_RAILS_OK_MASK);
	assign wr_ctrl = REG_WR_IN && (REG_ADDR_IN == ADDR_RAIL_ENABLE_CONTROL);
	assign wr_stat = REG_WR_IN && (REG_ADDR_IN == ADDR_RAIL_GOOD_STATUS);

	always_ff @(posedge MCLK_IN) begin
		if (!RESET_N_IN || UNDERVOLTAGE_LOCKOUT_IN) begin
			mask_q <= MASK_RESET;
		end else if (wr_mask) begin
			mask_q <= {2'b00, REG_WDATA_IN[MK_PAIR_BIT:0]};
		end
	end

	// a low pin wins over a software write and holds the bit at its reset value
	always_ff @(posedge MCLK_IN) begin
		if (!RESET_N_IN || UNDERVOLTAGE_LOCKOUT_IN) begin
			ctrl_q <= CTRL_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= REG_WDATA_IN;
			end
			if (!pin_b1_s) ctrl_q[G_B1] <= CTRL_RESET[G_B1];
			if (!pin_b2_s) ctrl_q[G_B2] <= CTRL_RESET[G_B2];
			if (!pin_b3_s) ctrl_q[G_B3] <= CTRL_RESET[G_B3];
			if (!pin_l_s) ctrl_q[G_L1] <= CTRL_RESET[G_L1];
			if (!pin_l_s) ctrl_q[G_L2] <= CTRL_RESET[G_L2];
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			dly_q <= DELAY_RESET;
		end else if (wr_stat) begin
			dly_q <= REG_WDATA_IN[ST_DLY_HI:ST_DLY_LO];
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			REG_RDATA_OUT <= 8'h00;
		end else if (REG_RD_IN) begin
			unique case (REG_ADDR_IN)
				ADDR_RAIL_GOOD_STATUS: REG_RDATA_OUT <= {comp_s, dly_q, good_s};
				ADDR_RAILS_OK_MASK: REG_RDATA_OUT <= mask_q;
				ADDR_RAIL_ENABLE_CONTROL: REG_RDATA_OUT <= ctrl_q;
				default: REG_RDATA_OUT <= 8'h00;
			endcase
		end
	end

	// sequencer
	pgs_seq_e state_q;
	logic [1:0] lvl_q;
	logic [2:0] code;
	logic ovr;
	logic [4:0] good_up;
	logic [4:0] good_dn;
	logic [4:0] cur_stage;
	logic stage_on;
	logic stage_off;
	logic gap_run;
	logic gap_done;

	assign code = ctrl_q[CT_ORDER_HI:CT_ORDER_LO];
	assign ovr = BUCK_THREE_PIN_OVERRIDE_IN;
	// the external regulator gives no feedback: counted good on, off at once
	assign good_up = {1'b1, good_s[G_L2], good_s[G_B3], good_s[G_B2], good_s[G_B1]};
	assign good_dn = {1'b0, good_s[G_L2], good_s[G_B3], good_s[G_B2], good_s[G_B1]};
	assign cur_stage = stage_rails(code, lvl_q, ovr);
	assign stage_on = ((cur_stage & good_up) == cur_stage);
	assign stage_off = ((cur_stage & good_dn) == SET_NONE);
	assign gap_run = (state_q == SEQ_UP) && (code == ORD_EXT_L2_B1B2) && (lvl_q == LVL_TWO);

	pgs_timer #(.CNT_W(CNT_W)) u_gap (
		.clk_in(MCLK_IN),
		.rst_n_in(RESET_N_IN),
		.run_in(gap_run),
		.limit_in(CNT_W'(ORDER_GAP_CYCLES)),
		.done_out(gap_done)
	);

	// in UP lvl_q is the stage being started; in DOWN the stage being drained
	always_ff @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			state_q <= SEQ_OFF;
			lvl_q <= LVL_ZERO;
		end else begin
			unique case (state_q)
				SEQ_OFF: begin
					if (ON_STATE_IN) begin
						state_q <= SEQ_UP;
						lvl_q <= LVL_ZERO;
					end
				end
				SEQ_UP: begin
					if (!ON_STATE_IN) begin
						state_q <= SEQ_DOWN;
					end else if (gap_run && !gap_done) begin
						state_q <= SEQ_UP;
					end else if (stage_on) begin
						if (lvl_q == LVL_TWO) begin
							state_q <= SEQ_ON;
						end else begin
							lvl_q <= lvl_q + 2'd1;
						end
					end
				end
				SEQ_ON: begin
					if (!ON_STATE_IN) begin
						state_q <= SEQ_DOWN;
						lvl_q <= LVL_TWO;
					end
				end
				SEQ_DOWN: begin
					if (stage_off) begin
						if (lvl_q == LVL_ZERO) begin
							state_q <= SEQ_OFF;
						end else begin
							lvl_q <= lvl_q - 2'd1;
						end
					end
				end
			endcase
		end
	end

	logic [4:0] seq_en;
	logic [4:0] auto_set;

	always_comb begin
		auto_set = stages_below(code, LVL_LAST, ovr);
		unique case (state_q)
			SEQ_OFF: seq_en = SET_NONE;
			// under order 111 the last stage stays off until the gap timer has run out
			SEQ_UP: seq_en = stages_below(code, (gap_run && !gap_done) ? lvl_q : lvl_q + 2'd1,
				ovr);
			SEQ_ON: seq_en = auto_set;
			SEQ_DOWN: seq_en = stages_below(code, lvl_q, ovr);
		endcase
	end

	logic on_st;
	assign on_st = (state_q != SEQ_OFF) && ON_STATE_IN;

	// ordered rails obey the sequencer and their bit, the external regulator the sequencer alone; others need pin and bit, bucks also the on state
	always_ff @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			BUCK_ONE_RUN_OUT <= 1'b0;
			BUCK_TWO_RUN_OUT <= 1'b0;
			BUCK_THREE_RUN_OUT <= 1'b0;
			LINEAR_REG_ONE_RUN_OUT <= 1'b0;
			LINEAR_REG_TWO_RUN_OUT <= 1'b0;
			EXTERNAL_REGULATOR_ENABLE_OUT <= 1'b0;
		end else begin
			BUCK_ONE_RUN_OUT <= ctrl_q[G_B1] && (auto_set[S_B1] ? seq_en[S_B1] :
				(pin_b1_s && on_st));
			BUCK_TWO_RUN_OUT <= ctrl_q[G_B2] && (auto_set[S_B2] ? seq_en[S_B2] :
				(pin_b2_s && on_st));
			BUCK_THREE_RUN_OUT <= ctrl_q[G_B3] && (auto_set[S_B3] ? seq_en[S_B3] :
				(pin_b3_s && on_st));
			LINEAR_REG_ONE_RUN_OUT <= ctrl_q[G_L1] && pin_l_s;
			LINEAR_REG_TWO_RUN_OUT <= ctrl_q[G_L2] && (auto_set[S_L2] ? seq_en[S_L2] :
				pin_l_s);
			EXTERNAL_REGULATOR_ENABLE_OUT <= seq_en[S_EXT];
		end
	end

	// rails-ok output: pull is immediate, release waits the selected delay
	logic pull;
	logic [CNT_W-1:0] dly_lim;
	logic rel_done;

	assign pull = (|(mask_q[MK_IND_HI:0] & ~good_s))
		|| (mask_q[MK_PAIR_BIT] && !good_s[G_B3] && !good_s[G_L1]);

	always_comb begin
		unique case (dly_q)
			DLY_20: dly_lim = CNT_W'(DELAY_20_CYCLES);
			DLY_100: dly_lim = CNT_W'(DELAY_100_CYCLES);
			DLY_200: dly_lim = CNT_W'(DELAY_200_CYCLES);
			default: dly_lim = CNT_W'(DELAY_400_CYCLES);
		endcase
	end

	pgs_timer #(.CNT_W(CNT_W)) u_release (
		.clk_in(MCLK_IN),
		.rst_n_in(RESET_N_IN),
		.run_in(!pull),
		.limit_in(dly_lim),
		.done_out(rel_done)
	);

	// open drain: only ever drives low
	assign RAILS_OK_OUTPUT_OUT = 1'b0;

	always_ff @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			RAILS_OK_OUTPUT_OE_OUT <= 1'b1;
		end else begin
			RAILS_OK_OUTPUT_OE_OUT <= !rel_done;
		end
	end
endmodule

// >>> common/pgs_pkg.sv
package pgs_pkg;

	// register offsets
	localparam logic [7:0] ADDR_RAIL_GOOD_STATUS = 8'h0B;
	localparam logic [7:0] ADDR_RAILS_OK_MASK = 8'h0C;
	localparam logic [7:0] ADDR_RAIL_ENABLE_CONTROL = 8'h0D;

	// status register fields
	localparam int ST_COMP_BIT = 7;
	localparam int ST_DLY_HI = 6;
	localparam int ST_DLY_LO = 5;
	localparam int ST_GOOD_HI = 4;

	// mask register fields
	localparam int MK_PAIR_BIT = 5;
	localparam int MK_IND_HI = 4;

	// control register fields
	localparam int CT_ORDER_HI = 7;
	localparam int CT_ORDER_LO = 5;
	localparam int CT_EN_HI = 4;

	// rail good / enable vector positions, same order as the status bits
	localparam int G_B1 = 4;
	localparam int G_B2 = 3;
	localparam int G_B3 = 2;
	localparam int G_L1 = 1;
	localparam int G_L2 = 0;

	// sequencer rail set positions
	localparam int S_B1 = 0;
	localparam int S_B2 = 1;
	localparam int S_B3 = 2;
	localparam int S_L2 = 3;
	localparam int S_EXT = 4;
	localparam logic [4:0] SET_NONE = 5'h00;

	// converter order codes
	localparam logic [2:0] ORD_B2 = 3'h0;
	localparam logic [2:0] ORD_B2B3 = 3'h1;
	localparam logic [2:0] ORD_B1_THEN_B2B3 = 3'h2;
	localparam logic [2:0] ORD_B3_THEN_B2 = 3'h3;
	localparam logic [2:0] ORD_L2_THEN_B1B2 = 3'h4;
	localparam logic [2:0] ORD_PINS = 3'h5;
	localparam logic [2:0] ORD_B1_B2_B3 = 3'h6;
	localparam logic [2:0] ORD_EXT_L2_B1B2 = 3'h7;

	// delay codes
	localparam logic [1:0] DLY_20 = 2'h0;
	localparam logic [1:0] DLY_100 = 2'h1;
	localparam logic [1:0] DLY_200 = 2'h2;

	// stage counting
	localparam logic [1:0] LVL_ZERO = 2'h0;
	localparam logic [1:0] LVL_ONE = 2'h1;
	localparam logic [1:0] LVL_TWO = 2'h2;
	localparam logic [1:0] LVL_LAST = 2'h3;

	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int NS_PER_MS = 1000000;
	localparam int T_DLY_20_MS = 20;
	localparam int T_DLY_100_MS = 100;
	localparam int T_DLY_200_MS = 200;
	localparam int T_DLY_400_MS = 400;
	localparam int T_ORDER_GAP_MS = 1;
	localparam int DLY_20_CYC = T_DLY_20_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int DLY_100_CYC = T_DLY_100_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int DLY_200_CYC = T_DLY_200_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int DLY_400_CYC = T_DLY_400_MS * (NS_PER_MS / CLK_PERIOD_NS);
	// strictly more than the gap, so one cycle extra
	localparam int ORDER_GAP_CYC = T_ORDER_GAP_MS * (NS_PER_MS / CLK_PERIOD_NS) + 1;

	// register defaults
	localparam logic [7:0] MASK_DEFAULT = 8'h08;
	localparam logic [7:0] CTRL_DEFAULT = 8'h1F;
	localparam logic [1:0] DELAY_DEFAULT = 2'h3;

	typedef enum logic [1:0] {
		SEQ_OFF = 2'b00,
		SEQ_UP = 2'b01,
		SEQ_ON = 2'b10,
		SEQ_DOWN = 2'b11
	} pgs_seq_e;

endpackage

// >>> src/pgs_sync.sv
`timescale 1ns/1ps
module pgs_sync import pgs_pkg::*; #(
	parameter int WIDTH = 10
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	if (WIDTH < 1) begin : g_width_chk
		$error("pgs_sync: WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a bit moves only once the last two stages agree, filtering one-cycle glitches
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sync_out <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					sync_out[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

// >>> src/pgs_timer.sv
`timescale 1ns/1ps
module pgs_timer import pgs_pkg::*; #(
	parameter int CNT_W = 27
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic run_in,
	input wire logic [CNT_W-1:0] limit_in,
	output logic done_out
);
	if (CNT_W < 2 || CNT_W > 31) begin : g_width_chk
		$error("pgs_timer: CNT_W out of range");
	end

	logic [CNT_W-1:0] cnt_q;

	// counts up to the limit while run is high, restarts whenever run drops
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || !run_in) begin
			cnt_q <= '0;
		end else if (cnt_q < limit_in) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign done_out = run_in && (cnt_q >= limit_in);
endmodule

// >>> test/pgs_rails.sv
`timescale 1ns/1ps
module pgs_rails import pgs_pkg::*; #(
	parameter int LAG = 6
) (
	input wire logic clk_in,
	input wire logic [4:0] run_in,
	input wire logic [4:0] fault_in,
	output logic [4:0] good_out
);
	// soft start: good only after LAG cycles of steady run, a disabled rail is never good
	logic [4:0] pipe_q [LAG];
	always_ff @(posedge clk_in) begin
		pipe_q[0] <= run_in;
		for (int i = 1; i < LAG; i++) begin
			pipe_q[i] <= pipe_q[i-1] & run_in;
		end
	end
	assign good_out = pipe_q[LAG-1] & run_in & ~fault_in;
endmodule

// >>> test/pgs_sequencer_sva.sv
`timescale 1ns/1ps
module pgs_sequencer_chk import pgs_pkg::*; (
	input wire logic MCLK_IN,
	input wire logic RESET_N_IN,
	input wire logic UNDERVOLTAGE_LOCKOUT_IN,
	input wire logic [4:0] RAIL_GOOD_IN,
	input wire logic BUCK_ONE_ENABLE_PIN_IN,
	input wire logic LINEAR_REG_ENABLE_PIN_IN,
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [7:0] REG_RDATA_OUT,
	input wire logic BUCK_ONE_RUN_OUT,
	input wire logic BUCK_TWO_RUN_OUT,
	input wire logic BUCK_THREE_RUN_OUT,
	input wire logic LINEAR_REG_ONE_RUN_OUT,
	input wire logic LINEAR_REG_TWO_RUN_OUT,
	input wire logic EXTERNAL_REGULATOR_ENABLE_OUT,
	input wire logic RAILS_OK_OUTPUT_OE_OUT
);
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	// shadow of the order field, so ordering checks know the active code
	logic [2:0] ord_q;
	always_ff @(posedge MCLK_IN) begin
		if (!RESET_N_IN || UNDERVOLTAGE_LOCKOUT_IN) begin
			ord_q <= CTRL_DEFAULT[7:5];
		end else if (REG_WR_IN && REG_ADDR_IN == ADDR_RAIL_ENABLE_CONTROL) begin
			ord_q <= REG_WDATA_IN[7:5];
		end
	end
	AST_LIN1_PIN: assert property (
		!LINEAR_REG_ENABLE_PIN_IN [*8] |=> !LINEAR_REG_ONE_RUN_OUT)
		else $error("linear one runs with its pin low");
	AST_OE_HOLD: assert property (
		$rose(RAILS_OK_OUTPUT_OE_OUT) |=> RAILS_OK_OUTPUT_OE_OUT [*8])
		else $error("rails ok released before its delay");
	AST_B2_AFTER_B1: assert property (
		ord_q == ORD_B1_B2_B3 && $rose(BUCK_TWO_RUN_OUT) |-> RAIL_GOOD_IN[G_B1])
		else $error("buck two started before buck one good");
	AST_B3_AFTER_B2: assert property (
		ord_q == ORD_B1_B2_B3 && $rose(BUCK_THREE_RUN_OUT) |-> RAIL_GOOD_IN[G_B2])
		else $error("buck three started before buck two good");
	AST_DOWN_ORDER: assert property (
		ord_q == ORD_B1_B2_B3 && $fell(BUCK_ONE_RUN_OUT)
		|-> !BUCK_TWO_RUN_OUT && !RAIL_GOOD_IN[G_B2])
		else $error("buck one dropped before buck two was off");
	AST_EXT_FIRST: assert property (
		ord_q == ORD_EXT_L2_B1B2 && $rose(LINEAR_REG_TWO_RUN_OUT)
		|-> EXTERNAL_REGULATOR_ENABLE_OUT)
		else $error("linear two started before external regulator");
	AST_GAP: assert property (
		ord_q == ORD_EXT_L2_B1B2 && $rose(LINEAR_REG_TWO_RUN_OUT)
		|=> !BUCK_ONE_RUN_OUT [*8])
		else $error("buck one too soon after linear two");
	AST_B1B2_AFTER_L2: assert property (
		ord_q == ORD_EXT_L2_B1B2 && $rose(BUCK_ONE_RUN_OUT)
		|-> RAIL_GOOD_IN[G_L2] ##[0:1] BUCK_TWO_RUN_OUT)
		else $error("bucks one and two not started together after linear two");
	AST_B2B3_AFTER_B1: assert property (
		ord_q == ORD_B1_THEN_B2B3 && $rose(BUCK_TWO_RUN_OUT)
		|-> RAIL_GOOD_IN[G_B1] && BUCK_THREE_RUN_OUT)
		else $error("bucks two and three not started together after buck one good");
	AST_B2_AFTER_B3: assert property (
		ord_q == ORD_B3_THEN_B2 && $rose(BUCK_TWO_RUN_OUT) |-> RAIL_GOOD_IN[G_B3])
		else $error("buck two started before buck three good");
	AST_B1B2_AFTER_L2_SEQ: assert property (
		ord_q == ORD_L2_THEN_B1B2 && $rose(BUCK_ONE_RUN_OUT)
		|-> RAIL_GOOD_IN[G_L2] && BUCK_TWO_RUN_OUT)
		else $error("bucks one and two started before linear two good");
	AST_B1_PIN0: assert property (
		(ord_q == ORD_B2 && !BUCK_ONE_ENABLE_PIN_IN) [*8] |=> !BUCK_ONE_RUN_OUT)
		else $error("buck one runs with pin low under code 000");
	AST_MASK_HI: assert property (
		REG_RD_IN && REG_ADDR_IN == ADDR_RAILS_OK_MASK |=> REG_RDATA_OUT[7:6] == 2'h0)
		else $error("mask upper bits read nonzero");
	cover property (ord_q == ORD_B1_B2_B3 && $rose(BUCK_THREE_RUN_OUT));
	cover property (ord_q == ORD_EXT_L2_B1B2 && $rose(BUCK_ONE_RUN_OUT));
	cover property ($fell(RAILS_OK_OUTPUT_OE_OUT));
	cover property (ord_q == ORD_L2_THEN_B1B2 && $rose(BUCK_ONE_RUN_OUT));
endmodule
bind pgs_sequencer pgs_sequencer_chk pgs_sequencer_chk_inst (.MCLK_IN, .RESET_N_IN,
	.UNDERVOLTAGE_LOCKOUT_IN, .RAIL_GOOD_IN, .BUCK_ONE_ENABLE_PIN_IN,
	.LINEAR_REG_ENABLE_PIN_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN,
	.REG_RDATA_OUT, .BUCK_ONE_RUN_OUT, .BUCK_TWO_RUN_OUT, .BUCK_THREE_RUN_OUT,
	.LINEAR_REG_ONE_RUN_OUT, .LINEAR_REG_TWO_RUN_OUT, .EXTERNAL_REGULATOR_ENABLE_OUT,
	.RAILS_OK_OUTPUT_OE_OUT);

// >>> test/pgs_sequencer_bench.sv
`timescale 1ns/1ps
module pgs_sequencer_bench import pgs_pkg::*;;
	localparam int D20 = 20;
	localparam int D100 = 40;
	localparam int D200 = 60;
	localparam int D400 = 80;
	localparam int GAP = 30;
	logic clk = 1'b0, rst_n = 1'b0, undervoltage_lockout = 1'b0, on = 1'b0, ovr = 1'b0, comp = 1'b1;
	logic p1 = 1'b0, p2 = 1'b0, p3 = 1'b0, pl = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
	logic [4:0] good, fault = 5'h00;
	logic b1, b2, b3, l1, l2, ext, ok, oe;
	int n_errors = 0, comparisons = 0, cyc;
	pgs_sequencer #(.DELAY_20_CYCLES(D20), .DELAY_100_CYCLES(D100), .DELAY_200_CYCLES(D200),
		.DELAY_400_CYCLES(D400), .ORDER_GAP_CYCLES(GAP)) pgs_sequencer_inst (
		.MCLK_IN(clk), .RESET_N_IN(rst_n), .UNDERVOLTAGE_LOCKOUT_IN(undervoltage_lockout),
		.ON_STATE_IN(on), .BUCK_THREE_PIN_OVERRIDE_IN(ovr), .RAIL_GOOD_IN(good),
		.RESET_COMPARATOR_IN(comp), .BUCK_ONE_ENABLE_PIN_IN(p1),
		.BUCK_TWO_ENABLE_PIN_IN(p2), .BUCK_THREE_ENABLE_PIN_IN(p3),
		.LINEAR_REG_ENABLE_PIN_IN(pl), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .BUCK_ONE_RUN_OUT(b1),
		.BUCK_TWO_RUN_OUT(b2), .BUCK_THREE_RUN_OUT(b3), .LINEAR_REG_ONE_RUN_OUT(l1),
		.LINEAR_REG_TWO_RUN_OUT(l2), .EXTERNAL_REGULATOR_ENABLE_OUT(ext),
		.RAILS_OK_OUTPUT_OUT(ok), .RAILS_OK_OUTPUT_OE_OUT(oe));
	pgs_rails pgs_rails_inst (.clk_in(clk), .run_in({b1, b2, b3, l1, l2}),
		.fault_in(fault), .good_out(good));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		v = rdata;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_for(input string what, ref logic sig, input logic lvl, input int lim);
		for (cyc = 0; cyc < lim && sig !== lvl; cyc++) begin
			@(negedge clk);
		end
		check(what, {7'h00, sig}, {7'h00, lvl});
	endtask
	task automatic seq_code(input logic [2:0] c, input logic o, input logic [3:0] exp);
		ovr = o;
		wr_reg(ADDR_RAIL_ENABLE_CONTROL, {c, 5'h1F});
		on = 1'b1;
		idle(120);
		check("order run", {4'h0, b1, b2, b3, l2}, {4'h0, exp});
		on = 1'b0;
		idle(120);
		check("order off", {4'h0, b1, b2, b3, l2}, 8'h00);
	endtask
	task automatic t_seq_codes();
		// all enable pins grounded, so only the ordered rails may run
		seq_code(ORD_B2, 1'b0, 4'b0100);
		seq_code(ORD_B2B3, 1'b0, 4'b0110);
		seq_code(ORD_B1_THEN_B2B3, 1'b0, 4'b1110);
		seq_code(ORD_B3_THEN_B2, 1'b0, 4'b0110);
		seq_code(ORD_L2_THEN_B1B2, 1'b1, 4'b1111);
		seq_code(ORD_L2_THEN_B1B2, 1'b0, 4'b1101);
		$display("done order codes");
	endtask
	task automatic rel_delay(input logic [1:0] c, input int d);
		wr_reg(ADDR_RAIL_GOOD_STATUS, {1'b0, c, 5'h00});
		fault = 5'h10;
		idle(8);
		fault = 5'h00;
		wait_for("released", oe, 1'b0, 200);
		check("delay", {7'h00, cyc >= d && cyc <= d + 10}, 8'h01);
	endtask
	task automatic t_regs();
		rd_reg(ADDR_RAILS_OK_MASK);
		check("mask reset", v, MASK_DEFAULT);
		rd_reg(ADDR_RAIL_ENABLE_CONTROL);
		check("ctrl reset", v, CTRL_DEFAULT);
		rd_reg(ADDR_RAIL_GOOD_STATUS);
		check("status reset", v, {1'b1, DELAY_DEFAULT, 5'h00});
		rd_reg(8'h00);
		check("unmapped", v, 8'h00);
		wr_reg(ADDR_RAILS_OK_MASK, 8'hFF);
		rd_reg(ADDR_RAILS_OK_MASK);
		check("mask upper", v, 8'h3F);
		undervoltage_lockout = 1'b1;
		wr_reg(ADDR_RAILS_OK_MASK, 8'h15);
		undervoltage_lockout = 1'b0;
		rd_reg(ADDR_RAILS_OK_MASK);
		check("mask undervoltage_lockout", v, MASK_DEFAULT);
		$display("done registers");
	endtask
	task automatic t_pins();
		wr_reg(ADDR_RAIL_ENABLE_CONTROL, 8'h1C);
		rd_reg(ADDR_RAIL_ENABLE_CONTROL);
		check("ctrl pin low", v, CTRL_DEFAULT);
		pl = 1'b1;
		comp = 1'b0;
		idle(8);
		wr_reg(ADDR_RAIL_ENABLE_CONTROL, 8'h1E);
		idle(12);
		check("linear runs", {6'h00, l1, l2}, 8'h02);
		rd_reg(ADDR_RAIL_GOOD_STATUS);
		check("status linear", v, {1'b0, DELAY_DEFAULT, 5'h02});
		pl = 1'b0;
		idle(8);
		rd_reg(ADDR_RAIL_ENABLE_CONTROL);
		check("ctrl reload", v, CTRL_DEFAULT);
		$display("done pins");
	endtask
	task automatic t_seq110();
		// buck pins stay grounded while ordered
		wr_reg(ADDR_RAIL_ENABLE_CONTROL, {ORD_B1_B2_B3, 5'h1F});
		on = 1'b1;
		wait_for("buck three up", b3, 1'b1, 200);
		check("bucks one two", {6'h00, b1, b2}, 8'h03);
		idle(12);
		rd_reg(ADDR_RAIL_GOOD_STATUS);
		check("status bucks", v, {1'b0, DELAY_DEFAULT, 5'h1C});
		on = 1'b0;
		wait_for("buck one down", b1, 1'b0, 200);
		check("bucks two three", {6'h00, b2, b3}, 8'h00);
		$display("done order 110");
	endtask
	task automatic t_seq111();
		wr_reg(ADDR_RAIL_ENABLE_CONTROL, {ORD_EXT_L2_B1B2, 5'h1F});
		on = 1'b1;
		wait_for("linear two up", l2, 1'b1, 100);
		check("ext before l2", {7'h00, ext}, 8'h01);
		wait_for("buck one up", b1, 1'b1, 300);
		check("gap after l2", {7'h00, cyc > GAP}, 8'h01);
		wait_for("buck two up", b2, 1'b1, 300);
		idle(2);
		check("ext l2 b1 b3", {4'h0, ext, l2, b1, b3}, 8'h0E);
		p3 = 1'b1;
		idle(10);
		check("buck three pin", {7'h00, b3}, 8'h01);
		on = 1'b0;
		p3 = 1'b0;
		wait_for("ext off", ext, 1'b0, 300);
		idle(20);
		check("all off", {3'h0, b1, b2, b3, l1, l2}, 8'h00);
		$display("done order 111");
	endtask
	task automatic t_rails_ok();
		wr_reg(ADDR_RAIL_ENABLE_CONTROL, {ORD_PINS, 5'h1F});
		wr_reg(ADDR_RAIL_GOOD_STATUS, {3'h0, 5'h1F});
		wr_reg(ADDR_RAILS_OK_MASK, 8'h10);
		p1 = 1'b1;
		on = 1'b1;
		wait_for("released", oe, 1'b0, 200);
		fault = 5'h10;
		idle(8);
		check("pulled", {7'h00, oe}, 8'h01);
		check("rails ok level", {7'h00, ok}, 8'h00);
		fault = 5'h00;
		wait_for("released", oe, 1'b0, 100);
		check("delay", {7'h00, cyc >= D20 && cyc <= D20 + 10}, 8'h01);
		rel_delay(DLY_100, D100);
		rel_delay(DLY_200, D200);
		rel_delay(2'h3, D400);
		rel_delay(DLY_20, D20);
		wr_reg(ADDR_RAILS_OK_MASK, 8'h20);
		idle(8);
		check("pair bad", {7'h00, oe}, 8'h01);
		pl = 1'b1;
		wait_for("pair half", oe, 1'b0, 100);
		wr_reg(ADDR_RAILS_OK_MASK, 8'h00);
		fault = 5'h1F;
		idle(30);
		check("no mask", {7'h00, oe}, 8'h00);
		fault = 5'h00;
		p1 = 1'b0;
		pl = 1'b0;
		on = 1'b0;
		$display("done rails ok");
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		idle(20);
		rst_n = 1'b1;
		t_regs();
		t_pins();
		t_seq110();
		t_seq111();
		t_seq_codes();
		t_rails_ok();
		close_out();
	end
	initial begin
		// about ten times the expected run
		#100000;
		n_errors++;
		close_out();
	end
endmodule
